// ==== spa_pkg.sv ====
// Shared constants for the serial program access front end.
package spa_pkg;
    // Four-byte SPI instruction framing.
    localparam int SPI_FRAME_BYTES = 4;
    localparam int SPI_BYTE_BITS = 8;
    localparam logic [4:0] SPI_RESP_LOAD_BIT = 5'h17;
    localparam logic [4:0] SPI_LAST_BIT = 5'h1F;
    // SPI instruction bytes.
    localparam logic [7:0] SPI_UNLOCK_B1 = 8'hAC;
    localparam logic [7:0] SPI_UNLOCK_B2 = 8'h53;
    localparam logic [7:0] SPI_FUSE_HIGH_B1 = 8'h58;
    localparam logic [7:0] SPI_FUSE_EXT_B1 = 8'h50;
    localparam logic [7:0] SPI_FUSE_RD_B2 = 8'h08;
    localparam logic [7:0] SPI_CALIB_B1 = 8'h38;
    localparam logic [7:0] SPI_CALIB_B2_MASK = 8'hC0;
    localparam logic [7:0] SPI_POLL_B1 = 8'hF0;
    localparam logic [7:0] SPI_ZERO_BYTE = 8'h00;
    localparam logic [7:0] SPI_IDLE_RESP = 8'h00;
    // Fuse polarity: zero means programmed.
    localparam logic FUSE_PROGRAMMED = 1'b0;
    localparam logic SCAN_FUSE_FACTORY = FUSE_PROGRAMMED;
    // Chip clocks from reset low to clearing the disable bit.
    localparam logic [1:0] DISABLE_CLEAR_CYCLES = 2'h2;
    // Test port instruction register and data registers.
    localparam int IR_WIDTH = 4;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] IR_PROGRAM_UNLOCK_INSTRUCTION = 4'h4;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam int UNLOCK_WIDTH = 16;
    localparam logic [15:0] UNLOCK_SIGNATURE = 16'hA370;
    localparam logic [15:0] UNLOCK_RESET = 16'h0000;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
        TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } spa_tap_type;
endpackage : spa_pkg

// ==== spa_pin_sync.sv ====
// Two-flop synchroniser with edge detection for a group of pin inputs.
`timescale 1ns/100ps
module spa_pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Raw pins
    input wire logic [WIDTH-1:0] pin,
    // Synchronised level and edges
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stage;
    logic [WIDTH-1:0] last;

    // Edges come from the second stage, never the metastable first.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            stage <= '0;
            last <= '0;
        end else begin
            meta <= pin;
            stage <= meta;
            last <= stage;
        end
    end

    assign level = stage;
    assign rise = stage & ~last;
    assign fall = ~stage & last;
endmodule : spa_pin_sync

// ==== spa_serial_program_access.sv ====
// Serial program access front end: SPI decoder and test port programming.
//
// Operation
// - Read 58 08 returns the high fuse byte.
// - Read 50 08 returns the extended fuse bits.
// - Read 38 with byte three zero returns the calibration byte.
// - Poll F0 00 returns the pending flag in bit zero.
// - Fields sit in their marked places; x positions are ignored.
// - Test port programming needs fuse programmed and disable bit cleared.
// - The enable fuse leaves the factory programmed.
// - Disable bit set with reset low clears it two chip clocks later.
// - Every test port shift register moves least significant bit first.
// - Instruction register is four bits, sixteen codes.
// - Each instruction selects one data register between data in and out.
// - Run-Test/Idle makes internal clocks and serves as idle point.
// - Enable instruction AC 53 under reset low unlocks SPI programming.
// - Unlock register must match the signature; cleared at power-on.
`timescale 1ns/100ps
module spa_serial_program_access (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // SPI programming pins
    input wire logic spi_sck,
    input wire logic spi_mosi,
    input wire logic reset_pin_n,
    output logic spi_miso,
    // Test port pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe_n,
    // Device state read by the instructions
    input wire logic [7:0] fuse_high,
    input wire logic [7:0] fuse_ext,
    input wire logic [7:0] calib_byte,
    input wire logic operation_pending_flag,
    input wire logic scan_port_enable_fuse,
    // Software access to the disable bit of the control/status register
    input wire logic scan_port_disable_set,
    input wire logic scan_port_disable_clear,
    output logic scan_port_disable_bit,
    // Status
    output logic spi_prog_enabled,
    output logic spi_instr_done,
    output logic [31:0] spi_instr,
    output logic scan_prog_allowed,
    output logic scan_prog_enabled,
    output logic [3:0] scan_instr,
    output logic run_idle_clock
);
    logic [5:0] pin_level;
    logic [5:0] pin_rise;
    logic [5:0] pin_fall;
    logic sck_rise;
    logic sck_fall;
    logic mosi_in;
    logic reset_low;
    logic tck_rise;
    logic tck_fall;
    logic tms_in;
    logic tdi_in;

    // Reset enters inverted so a cleared synchroniser reads it released.
    spa_pin_sync #(.WIDTH(6)) u_sync (
        .clk(clk),
        .rst(rst),
        .pin({tdi, tms, tck, ~reset_pin_n, spi_mosi, spi_sck}),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    assign sck_rise = pin_rise[0];
    assign sck_fall = pin_fall[0];
    assign mosi_in = pin_level[1];
    assign reset_low = pin_level[2];
    assign tck_rise = pin_rise[3];
    assign tck_fall = pin_fall[3];
    assign tms_in = pin_level[4];
    assign tdi_in = pin_level[5];

    // Response byte for the fourth byte, chosen from the first three.
    function automatic logic [7:0] spa_response(input logic [23:0] head, input logic [7:0] fh, fe, cal,
                                                input logic busy);
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
        b1 = head[23:16];
        b2 = head[15:8];
        b3 = head[7:0];
        spa_response = spa_pkg::SPI_IDLE_RESP;
        if (b1 == spa_pkg::SPI_FUSE_HIGH_B1 && b2 == spa_pkg::SPI_FUSE_RD_B2) begin
            spa_response = fh;
        end else if (b1 == spa_pkg::SPI_FUSE_EXT_B1 && b2 == spa_pkg::SPI_FUSE_RD_B2) begin
            spa_response = fe;
        end else if (b1 == spa_pkg::SPI_CALIB_B1 && (b2 & spa_pkg::SPI_CALIB_B2_MASK) == spa_pkg::SPI_ZERO_BYTE
                     && b3 == spa_pkg::SPI_ZERO_BYTE) begin
            spa_response = cal;
        end else if (b1 == spa_pkg::SPI_POLL_B1 && b2 == spa_pkg::SPI_ZERO_BYTE) begin
            spa_response = {7'h00, busy};
        end
    endfunction : spa_response

    // SPI frame state.
    logic [4:0] bit_count;
    logic [31:0] in_shift;
    logic [7:0] out_shift;
    logic next_miso;
    logic [4:0] next_bit_count;
    logic [31:0] next_in_shift;
    logic [7:0] next_out_shift;
    logic next_spi_prog_enabled;
    logic next_spi_instr_done;
    logic [31:0] next_spi_instr;
    logic [31:0] shifted;

    always_comb begin
        shifted = {in_shift[30:0], mosi_in};
        next_bit_count = bit_count;
        next_in_shift = in_shift;
        next_out_shift = out_shift;
        next_miso = spi_miso;
        next_spi_prog_enabled = spi_prog_enabled;
        next_spi_instr_done = 1'b0;
        next_spi_instr = spi_instr;
        if (!reset_low) begin
            // Releasing reset ends programming and abandons any partial frame.
            next_bit_count = '0;
            next_in_shift = '0;
            next_out_shift = spa_pkg::SPI_IDLE_RESP;
            next_miso = 1'b0;
            next_spi_prog_enabled = 1'b0;
        end else begin
            if (sck_rise) begin
                next_in_shift = shifted;
                next_bit_count = bit_count + 5'h01;
                if (bit_count == spa_pkg::SPI_RESP_LOAD_BIT && spi_prog_enabled) begin
                    next_out_shift = spa_response(shifted[23:0], fuse_high, fuse_ext, calib_byte,
                                                  operation_pending_flag);
                end
                if (bit_count == spa_pkg::SPI_LAST_BIT) begin
                    next_bit_count = '0;
                    next_spi_instr_done = 1'b1;
                    next_spi_instr = shifted;
                    if (shifted[31:24] == spa_pkg::SPI_UNLOCK_B1 && shifted[23:16] == spa_pkg::SPI_UNLOCK_B2) begin
                        next_spi_prog_enabled = 1'b1;
                    end
                end
            end
            if (sck_fall) begin
                // Data changes on the falling edge, stable at the host's rising edge.
                next_miso = out_shift[7];
                next_out_shift = {out_shift[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_count <= '0;
            in_shift <= '0;
            out_shift <= spa_pkg::SPI_IDLE_RESP;
            spi_miso <= 1'b0;
            spi_prog_enabled <= 1'b0;
            spi_instr_done <= 1'b0;
            spi_instr <= '0;
        end else begin
            bit_count <= next_bit_count;
            in_shift <= next_in_shift;
            out_shift <= next_out_shift;
            spi_miso <= next_miso;
            spi_prog_enabled <= next_spi_prog_enabled;
            spi_instr_done <= next_spi_instr_done;
            spi_instr <= next_spi_instr;
        end
    end

    // Disable bit of the control/status register.
    logic [1:0] clear_count;
    logic next_disable;
    logic [1:0] next_clear_count;

    always_comb begin
        next_disable = scan_port_disable_bit;
        next_clear_count = '0;
        if (scan_port_disable_bit && reset_low) begin
            next_clear_count = clear_count + 2'h1;
            if (next_clear_count == spa_pkg::DISABLE_CLEAR_CYCLES) begin
                next_disable = 1'b0;
                next_clear_count = '0;
            end
        end
        if (scan_port_disable_clear) begin
            next_disable = 1'b0;
        end
        if (scan_port_disable_set) begin
            next_disable = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scan_port_disable_bit <= 1'b0;
            clear_count <= '0;
        end else begin
            scan_port_disable_bit <= next_disable;
            clear_count <= next_clear_count;
        end
    end

    // The fuse is programmed when it reads zero, its factory state.
    assign scan_prog_allowed = (scan_port_enable_fuse == spa_pkg::SCAN_FUSE_FACTORY) && !scan_port_disable_bit;

    // Test access port controller, stepped on sampled test clock rises.
    spa_pkg::spa_tap_type tap_state;
    spa_pkg::spa_tap_type next_tap_state;
    logic [3:0] ir_shift;
    logic [15:0] unlock_reg;
    logic bypass_reg;
    logic next_tdo;
    logic next_tdo_oe_n;
    logic next_run_idle_clock;
    logic next_scan_prog_enabled;
    logic [3:0] next_scan_instr;
    logic [3:0] next_ir_shift;
    logic [15:0] next_unlock_reg;
    logic next_bypass_reg;

    always_comb begin
        next_tap_state = tap_state;
        next_ir_shift = ir_shift;
        next_unlock_reg = unlock_reg;
        next_bypass_reg = bypass_reg;
        next_scan_instr = scan_instr;
        next_scan_prog_enabled = scan_prog_enabled;
        next_tdo = tdo;
        next_tdo_oe_n = tdo_oe_n;
        next_run_idle_clock = 1'b0;
        if (!scan_prog_allowed) begin
            // With the port withheld the controller stays reset.
            next_tap_state = spa_pkg::TAP_RESET;
            next_scan_instr = spa_pkg::IR_BYPASS;
            next_scan_prog_enabled = 1'b0;
            next_tdo_oe_n = 1'b1;
        end else begin
            if (tck_rise) begin
                unique case (tap_state)
                    spa_pkg::TAP_RESET: next_tap_state = tms_in ? spa_pkg::TAP_RESET : spa_pkg::TAP_IDLE;
                    spa_pkg::TAP_IDLE: next_tap_state = tms_in ? spa_pkg::TAP_SEL_DR : spa_pkg::TAP_IDLE;
                    spa_pkg::TAP_SEL_DR: next_tap_state = tms_in ? spa_pkg::TAP_SEL_IR : spa_pkg::TAP_CAP_DR;
                    spa_pkg::TAP_CAP_DR: next_tap_state = tms_in ? spa_pkg::TAP_EXIT1_DR : spa_pkg::TAP_SHIFT_DR;
                    spa_pkg::TAP_SHIFT_DR: next_tap_state = tms_in ? spa_pkg::TAP_EXIT1_DR : spa_pkg::TAP_SHIFT_DR;
                    spa_pkg::TAP_EXIT1_DR: next_tap_state = tms_in ? spa_pkg::TAP_UPD_DR : spa_pkg::TAP_PAUSE_DR;
                    spa_pkg::TAP_PAUSE_DR: next_tap_state = tms_in ? spa_pkg::TAP_EXIT2_DR : spa_pkg::TAP_PAUSE_DR;
                    spa_pkg::TAP_EXIT2_DR: next_tap_state = tms_in ? spa_pkg::TAP_UPD_DR : spa_pkg::TAP_SHIFT_DR;
                    spa_pkg::TAP_UPD_DR: next_tap_state = tms_in ? spa_pkg::TAP_SEL_DR : spa_pkg::TAP_IDLE;
                    spa_pkg::TAP_SEL_IR: next_tap_state = tms_in ? spa_pkg::TAP_RESET : spa_pkg::TAP_CAP_IR;
                    spa_pkg::TAP_CAP_IR: next_tap_state = tms_in ? spa_pkg::TAP_EXIT1_IR : spa_pkg::TAP_SHIFT_IR;
                    spa_pkg::TAP_SHIFT_IR: next_tap_state = tms_in ? spa_pkg::TAP_EXIT1_IR : spa_pkg::TAP_SHIFT_IR;
                    spa_pkg::TAP_EXIT1_IR: next_tap_state = tms_in ? spa_pkg::TAP_UPD_IR : spa_pkg::TAP_PAUSE_IR;
                    spa_pkg::TAP_PAUSE_IR: next_tap_state = tms_in ? spa_pkg::TAP_EXIT2_IR : spa_pkg::TAP_PAUSE_IR;
                    spa_pkg::TAP_EXIT2_IR: next_tap_state = tms_in ? spa_pkg::TAP_UPD_IR : spa_pkg::TAP_SHIFT_IR;
                    spa_pkg::TAP_UPD_IR: next_tap_state = tms_in ? spa_pkg::TAP_SEL_DR : spa_pkg::TAP_IDLE;
                endcase
                unique case (tap_state)
                    spa_pkg::TAP_RESET: next_scan_instr = spa_pkg::IR_BYPASS;
                    spa_pkg::TAP_IDLE: next_run_idle_clock = 1'b1;
                    spa_pkg::TAP_CAP_IR: next_ir_shift = spa_pkg::IR_CAPTURE;
                    spa_pkg::TAP_SHIFT_IR: next_ir_shift = {tdi_in, ir_shift[3:1]};
                    spa_pkg::TAP_UPD_IR: next_scan_instr = ir_shift;
                    spa_pkg::TAP_CAP_DR: next_bypass_reg = 1'b0;
                    spa_pkg::TAP_SHIFT_DR: begin
                        if (scan_instr == spa_pkg::IR_PROGRAM_UNLOCK_INSTRUCTION) begin
                            next_unlock_reg = {tdi_in, unlock_reg[15:1]};
                        end else begin
                            next_bypass_reg = tdi_in;
                        end
                    end
                    spa_pkg::TAP_UPD_DR: begin
                        if (scan_instr == spa_pkg::IR_PROGRAM_UNLOCK_INSTRUCTION) begin
                            next_scan_prog_enabled = (unlock_reg == spa_pkg::UNLOCK_SIGNATURE);
                        end
                    end
                    default: next_run_idle_clock = 1'b0;
                endcase
            end
            if (tck_fall) begin
                // Output changes on the falling edge, ahead of the host's sample.
                next_tdo_oe_n = 1'b1;
                if (tap_state == spa_pkg::TAP_SHIFT_IR) begin
                    next_tdo = ir_shift[0];
                    next_tdo_oe_n = 1'b0;
                end else if (tap_state == spa_pkg::TAP_SHIFT_DR) begin
                    next_tdo = (scan_instr == spa_pkg::IR_PROGRAM_UNLOCK_INSTRUCTION) ? unlock_reg[0] : bypass_reg;
                    next_tdo_oe_n = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tap_state <= spa_pkg::TAP_RESET;
            ir_shift <= spa_pkg::IR_CAPTURE;
            unlock_reg <= spa_pkg::UNLOCK_RESET;
            bypass_reg <= 1'b0;
            scan_instr <= spa_pkg::IR_BYPASS;
            scan_prog_enabled <= 1'b0;
            tdo <= 1'b0;
            tdo_oe_n <= 1'b1;
            run_idle_clock <= 1'b0;
        end else begin
            tap_state <= next_tap_state;
            ir_shift <= next_ir_shift;
            unlock_reg <= next_unlock_reg;
            bypass_reg <= next_bypass_reg;
            scan_instr <= next_scan_instr;
            scan_prog_enabled <= next_scan_prog_enabled;
            tdo <= next_tdo;
            tdo_oe_n <= next_tdo_oe_n;
            run_idle_clock <= next_run_idle_clock;
        end
    end
endmodule : spa_serial_program_access

// ==== spa_serial_program_access_checker.sv ====
// Concurrent checks on the ports of the serial program access front end.
`timescale 1ns/100ps
module spa_serial_program_access_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins and device state
    input wire logic reset_pin_n,
    input wire logic scan_port_enable_fuse,
    input wire logic scan_port_disable_set,
    input wire logic scan_port_disable_clear,
    input wire logic tdo_oe_n,
    // Status
    input wire logic scan_port_disable_bit,
    input wire logic spi_prog_enabled,
    input wire logic spi_instr_done,
    input wire logic [31:0] spi_instr,
    input wire logic scan_prog_allowed,
    input wire logic scan_prog_enabled,
    input wire logic [3:0] scan_instr,
    input wire logic run_idle_clock
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_ALLOWED: assert property (scan_prog_allowed == (!scan_port_enable_fuse && !scan_port_disable_bit))
        else $error("allowed does not follow fuse and disable bit");
    AST_DISABLE_SET: assert property (scan_port_disable_set |=> scan_port_disable_bit)
        else $error("disable bit not set");
    AST_DISABLE_SW_CLEAR: assert property (scan_port_disable_clear && !scan_port_disable_set |=> !scan_port_disable_bit)
        else $error("disable bit not cleared");
    // The pin synchroniser delays the two chip clocks by a few cycles.
    AST_DISABLE_HW_CLEAR: assert property ($fell(reset_pin_n) && scan_port_disable_bit && !scan_port_disable_set
        |-> ##[2:6] !scan_port_disable_bit)
        else $error("disable bit kept under reset pin low");
    AST_WITHHELD: assert property (!scan_prog_allowed ##1 !scan_prog_allowed
        |-> tdo_oe_n && scan_instr == spa_pkg::IR_BYPASS && !scan_prog_enabled)
        else $error("test port active while withheld");
    AST_TDO_DRIVE: assert property (!tdo_oe_n |-> $past(scan_prog_allowed))
        else $error("data out driven while port withheld");
    AST_DONE_PULSE: assert property (spi_instr_done |=> !spi_instr_done)
        else $error("done longer than one cycle");
    AST_INSTR_AT_DONE: assert property (!$stable(spi_instr) |-> spi_instr_done)
        else $error("instruction changed without frame end");
    AST_UNLOCK: assert property ($rose(spi_prog_enabled)
        |-> spi_instr_done && spi_instr[31:16] == {spa_pkg::SPI_UNLOCK_B1, spa_pkg::SPI_UNLOCK_B2})
        else $error("SPI enabled without unlock frame");
    AST_SCAN_ENABLE: assert property ($rose(scan_prog_enabled)
        |-> scan_prog_allowed && scan_instr == spa_pkg::IR_PROGRAM_UNLOCK_INSTRUCTION)
        else $error("test port enabled without unlock");
    AST_IDLE_CLOCK: assert property (run_idle_clock |=> !run_idle_clock && tdo_oe_n)
        else $error("idle clock not a single pulse");

    COV_SPI_UNLOCK: cover property ($rose(spi_prog_enabled));
    COV_SCAN_UNLOCK: cover property ($rose(scan_prog_enabled));
    COV_IDLE_CLOCK: cover property (run_idle_clock);
    COV_HW_CLEAR: cover property ($fell(scan_port_disable_bit) && !reset_pin_n);
endmodule : spa_serial_program_access_checker

bind spa_serial_program_access spa_serial_program_access_checker chk (
    .clk(clk), .rst(rst), .reset_pin_n(reset_pin_n), .scan_port_enable_fuse(scan_port_enable_fuse),
    .scan_port_disable_set(scan_port_disable_set), .scan_port_disable_clear(scan_port_disable_clear),
    .tdo_oe_n(tdo_oe_n), .scan_port_disable_bit(scan_port_disable_bit), .spi_prog_enabled(spi_prog_enabled),
    .spi_instr_done(spi_instr_done), .spi_instr(spi_instr), .scan_prog_allowed(scan_prog_allowed),
    .scan_prog_enabled(scan_prog_enabled), .scan_instr(scan_instr), .run_idle_clock(run_idle_clock)
);

// ==== spa_programmer.sv ====
// Behavioural external programmer driving the SPI and test port pins.
`timescale 1ns/100ps
module spa_programmer (
    // SPI side
    output logic spi_sck,
    output logic spi_mosi,
    output logic reset_pin_n,
    input wire logic spi_miso,
    // Test port side
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    localparam real HALF = 62.5;

    initial begin
        spi_sck = 1'b0;
        spi_mosi = 1'b0;
        reset_pin_n = 1'b1;
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    task automatic hold_reset(input logic level);
        reset_pin_n = level;
    endtask : hold_reset

    // The serial clock runs only inside a frame; byte four is sampled before each rise.
    task automatic spi_frame(input logic [31:0] cmd, output logic [7:0] resp);
        for (int i = 31; i >= 0; i--) begin
            spi_mosi = cmd[i];
            #(HALF);
            if (i < 8) resp = {resp[6:0], spi_miso};
            spi_sck = 1'b1;
            #(HALF);
            spi_sck = 1'b0;
        end
        // Inverting the data line after the frame exposes late sampling.
        spi_mosi = ~cmd[0];
        #(HALF);
    endtask : spi_frame

    // Only the four test port pins are used here, never reset or the chip clock.
    task automatic tap(input logic tms_v, input logic tdi_v, output logic tdo_v);
        tms = tms_v;
        tdi = tdi_v;
        #(HALF);
        tdo_v = tdo;
        tck = 1'b1;
        #(HALF);
        tck = 1'b0;
    endtask : tap
endmodule : spa_programmer

// ==== test_serial_program_access.sv ====
// Self-checking bench for the serial program access front end.
`timescale 1ns/100ps
module test_serial_program_access;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic spi_sck, spi_mosi, reset_pin_n, spi_miso, tck, tms, tdi, tdo, tdo_oe_n;
    logic [7:0] fuse_high = 8'h00, fuse_ext = 8'h00, calib_byte = 8'h00;
    logic operation_pending_flag = 1'b0, scan_port_enable_fuse = 1'b1;
    logic scan_port_disable_set = 1'b0, scan_port_disable_clear = 1'b0;
    logic scan_port_disable_bit, spi_prog_enabled, spi_instr_done, scan_prog_allowed, scan_prog_enabled;
    logic run_idle_clock;
    logic [31:0] spi_instr;
    logic [3:0] scan_instr;
    logic [15:0] lfsr = 16'h0019;
    logic unlocked = 1'b0;
    int n_mismatch = 0;
    int total_checks = 0;
    int idle_count = 0;

    always #2 clk = ~clk;
    always @(posedge clk) if (run_idle_clock === 1'b1) idle_count <= idle_count + 1;

    spa_serial_program_access uut (
        .clk(clk), .rst(rst), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .reset_pin_n(reset_pin_n),
        .spi_miso(spi_miso), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
        .fuse_high(fuse_high), .fuse_ext(fuse_ext), .calib_byte(calib_byte),
        .operation_pending_flag(operation_pending_flag), .scan_port_enable_fuse(scan_port_enable_fuse),
        .scan_port_disable_set(scan_port_disable_set), .scan_port_disable_clear(scan_port_disable_clear),
        .scan_port_disable_bit(scan_port_disable_bit), .spi_prog_enabled(spi_prog_enabled),
        .spi_instr_done(spi_instr_done), .spi_instr(spi_instr), .scan_prog_allowed(scan_prog_allowed),
        .scan_prog_enabled(scan_prog_enabled), .scan_instr(scan_instr), .run_idle_clock(run_idle_clock)
    );

    spa_programmer prog (
        .spi_sck(spi_sck), .spi_mosi(spi_mosi), .reset_pin_n(reset_pin_n), .spi_miso(spi_miso),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo ^ tdo_oe_n)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expected);
        total_checks++;
        if (seen !== expected) begin
            n_mismatch++;
            $display("Error %s expected %0h seen %0h", what, expected, seen);
        end
    endtask : check

    task automatic end_of_test();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : next_rand

    function automatic logic [7:0] model_resp(input logic [31:0] c);
        if (!unlocked) return 8'h00;
        if (c[31:16] == 16'h5808) return fuse_high;
        if (c[31:16] == 16'h5008) return fuse_ext;
        if (c[31:24] == 8'h38 && c[23:22] == 2'h0 && c[15:8] == 8'h00) return calib_byte;
        if (c[31:16] == 16'hF000) return {7'h00, operation_pending_flag};
        return 8'h00;
    endfunction : model_resp

    task automatic spi_cmd(input logic [31:0] c);
        logic [7:0] resp, expected;
        expected = model_resp(c);
        prog.spi_frame(c, resp);
        check("spi_response", 32'(resp), 32'(expected));
        check("spi_instr", spi_instr, c);
        if (c[31:16] == 16'hAC53) unlocked = 1'b1;
        check("spi_prog_enabled", 32'(spi_prog_enabled), 32'(unlocked));
    endtask : spi_cmd

    task automatic pulse(input logic set);
        @(negedge clk);
        scan_port_disable_set = set;
        scan_port_disable_clear = !set;
        @(negedge clk);
        scan_port_disable_set = 1'b0;
        scan_port_disable_clear = 1'b0;
        @(negedge clk);
    endtask : pulse

    // Starts and ends in Run-Test/Idle; data moves least significant bit first.
    task automatic scan(input logic ir, input int n, input logic [15:0] din, output logic [15:0] dout);
        logic b;
        dout = 16'h0000;
        prog.tap(1'b1, 1'b0, b);
        if (ir) prog.tap(1'b1, 1'b0, b);
        prog.tap(1'b0, 1'b0, b);
        prog.tap(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            prog.tap(i == n - 1, din[i], b);
            dout[i] = b;
        end
        prog.tap(1'b1, 1'b0, b);
        prog.tap(1'b0, 1'b0, b);
    endtask : scan

    initial begin
        logic [15:0] d;
        logic [31:0] c;
        logic [7:0] ops [5], b2s [5];
        ops = '{8'h58, 8'h50, 8'h38, 8'hF0, 8'hAC};
        b2s = '{8'h08, 8'h08, 8'h00, 8'h00, 8'h53};
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        check("tdo_oe_n", 32'(tdo_oe_n), 32'h1);
        check("scan_instr", 32'(scan_instr), 32'hF);
        check("scan_prog_allowed", 32'(scan_prog_allowed), 32'h0);
        scan_port_enable_fuse = 1'b0;
        pulse(1'b1);
        check("scan_port_disable_bit", 32'(scan_port_disable_bit), 32'h1);
        pulse(1'b0);
        check("scan_port_disable_bit", 32'(scan_port_disable_bit), 32'h0);
        pulse(1'b1);
        prog.hold_reset(1'b0);
        repeat (10) @(negedge clk);
        check("scan_port_disable_bit", 32'(scan_port_disable_bit), 32'h0);
        check("scan_prog_allowed", 32'(scan_prog_allowed), 32'h1);
        spi_cmd(32'h58080000);
        spi_cmd(32'hAC530000);
        for (int k = 0; k < 25; k++) begin
            lfsr = next_rand(lfsr);
            @(negedge clk);
            fuse_high = lfsr[7:0];
            fuse_ext = lfsr[15:8];
            calib_byte = lfsr[12:5];
            operation_pending_flag = lfsr[0];
            c = {ops[k % 5], lfsr[3:2] == 2'h0 ? lfsr[15:8] : b2s[k % 5], lfsr[4] ? lfsr[15:8] : 8'h00, lfsr[7:0]};
            spi_cmd(c);
        end
        prog.hold_reset(1'b1);
        unlocked = 1'b0;
        repeat (8) @(negedge clk);
        check("spi_prog_enabled", 32'(spi_prog_enabled), 32'h0);
        prog.hold_reset(1'b0);
        repeat (8) @(negedge clk);
        spi_cmd(32'hF0000000);
        prog.tap(1'b0, 1'b0, d[0]);
        scan(1'b1, 4, 16'h0004, d);
        check("ir_capture", 32'(d[3:0]), 32'h1);
        check("scan_instr", 32'(scan_instr), 32'h4);
        scan(1'b0, 16, 16'hA370, d);
        check("scan_prog_enabled", 32'(scan_prog_enabled), 32'h1);
        idle_count = 0;
        repeat (5) prog.tap(1'b0, 1'b0, d[0]);
        check("run_idle_clock", 32'(idle_count), 32'h5);
        scan(1'b0, 16, 16'hA371, d);
        check("scan_prog_enabled", 32'(scan_prog_enabled), 32'h0);
        scan(1'b1, 4, 16'h000F, d);
        lfsr = next_rand(lfsr);
        scan(1'b0, 8, lfsr, d);
        check("bypass_out", 32'(d[7:0]), 32'({lfsr[6:0], 1'b0}));
        @(negedge clk);
        scan_port_enable_fuse = 1'b1;
        repeat (4) @(negedge clk);
        check("scan_instr", 32'(scan_instr), 32'hF);
        end_of_test();
    end

    initial begin
        #300us;
        n_mismatch++;
        end_of_test();
    end
endmodule : test_serial_program_access
